// ==== testbench/sacc_far_model.sv ====
// Purpose: far side of the converter: timers, start strobe and comparator
// Assumes: timer and strobe outputs change on the mclk edge by nonblocking assignment; the comparator output is combinational
// Notes: fire 1 t0, 2 t2 low, 3 t1, 4 t2 high, 5 strobe up, 6 strobe down
`timescale 1ns/1ns
module sacc_far_model (
  input wire logic mclk, // system clock
  input wire logic [2:0] fire, // event request from the bench
  input wire logic [7:0] level, // analog input as unsigned code
  input wire logic [7:0] sar_trial, // dac trial code
  output logic timer0_ovf, // timer 0 overflow
  output logic timer1_ovf, // timer 1 overflow
  output logic timer2_low_ovf, // timer 2 low byte overflow
  output logic timer2_high_ovf, // timer 2 high byte overflow
  output logic external_start_strobe, // start strobe level
  output logic cmp_above // comparator result
);
  initial begin
    {timer0_ovf, timer1_ovf, timer2_low_ovf, timer2_high_ovf} = 4'h0;
    external_start_strobe = 1'b0;
  end
  // request read on the edge, before the bench moves it, so there is no race
  always @(posedge mclk) begin
    timer0_ovf <= (fire == 3'h1);
    timer2_low_ovf <= (fire == 3'h2);
    timer1_ovf <= (fire == 3'h3);
    timer2_high_ovf <= (fire == 3'h4);
    if (fire == 3'h5) external_start_strobe <= 1'b1;
    else if (fire == 3'h6) external_start_strobe <= 1'b0;
  end
  // ideal comparator on the unsigned scale; differential coding is the design's job
  assign cmp_above = (level >= sar_trial);
endmodule

// ==== testbench/sacc_top_tb.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: inputs driven 1 ns after the rising edge of mclk
// Notes: random settings from a fixed seed, every start source in turn
`timescale 1ns/1ns
module sacc_top_tb;
  import sacc_pkg::*;
  logic mclk = 0, rst = 1, en = 0, tm = 0, bw = 0, dclr = 0, irqen = 0, split8 = 0, stby = 0;
  logic [2:0] mode = 3'h0, fire = 3'h0;
  logic [4:0] div = 5'h00;
  logic [1:0] gsel = 2'h0, pga_gain;
  logic [3:0] pos = 4'h0, neg = 4'h8, pos_sel;
  logic [7:0] level = 8'h00, res, trial;
  logic t0, t1, t2l, t2h, strobe, cmp, busy, done, irq, track, tick, diffm, ngnd, prsv;
  logic [2:0] neg_sel;
  logic [31:0] seed = 32'd50466;
  int n_errors = 0, compares = 0, n_trk = 0;
  always #20 mclk = ~mclk;
  sacc_far_model far (.mclk(mclk), .fire(fire), .level(level), .sar_trial(trial),
    .timer0_ovf(t0), .timer1_ovf(t1), .timer2_low_ovf(t2l), .timer2_high_ovf(t2h),
    .external_start_strobe(strobe), .cmp_above(cmp));
  sacc_top dut (.mclk(mclk), .rst(rst), .converter_enable_bit(en), .track_mode_bit(tm),
    .start_mode_field(mode), .busy_write_one(bw), .done_flag_clear(dclr),
    .done_irq_enable(irqen), .sar_clock_divider_field(div), .gain_select_field(gsel),
    .positive_input_field(pos), .negative_input_field(neg), .timer0_ovf(t0),
    .timer1_ovf(t1), .timer2_low_ovf(t2l), .timer2_high_ovf(t2h), .timer2_split8(split8),
    .external_start_strobe(strobe), .standby(stby), .cmp_above(cmp),
    .conversion_result_reg(res), .conversion_busy_bit(busy), .conversion_done_flag(done),
    .done_irq(irq), .track_en(track), .sar_clk_en(tick), .sar_trial(trial),
    .diff_mode(diffm), .pga_gain(pga_gain), .pos_sel(pos_sel), .neg_sel(neg_sel),
    .neg_gnd(ngnd), .pos_reserved(prsv));
  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // counts the sar clocks spent tracking, as seen just before each edge
  task automatic cyc();
    if (tick === 1'b1 && track === 1'b1) n_trk++;
    @(posedge mclk);
    #1;
  endtask
  // unsigned code of the input; sign bit flipped when the negative input is a pin
  function automatic logic [7:0] code_of(input logic [7:0] lv, input logic [3:0] ng);
    return ng[3] ? lv : lv ^ SIGN_FLIP;
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic conv(input int s);
    int t;
    int last;
    logic [7:0] exp;
    exp = code_of(level, neg);
    mode = (s < 4) ? 3'(s) : {1'b1, seed[25:24]};
    // a source other than the selected one must not start anything
    if (s == 0) fire = 3'h1;
    else bw = 1'b1;
    cyc();
    bw = 1'b0;
    fire = (s == 2) ? (split8 ? 3'h4 : 3'h2) : 3'h0;
    repeat (4) cyc();
    chk("wrong source", {7'h0, busy}, 8'h00);
    if (!tm || s == 4) chk("idle track", {7'h0, track}, 8'h01);
    n_trk = 0;
    case (s)
      0: bw = 1'b1;
      1: fire = 3'h1;
      2: fire = split8 ? 3'h2 : 3'h4;
      3: fire = 3'h3;
      default: fire = 3'h5;
    endcase
    cyc();
    bw = 1'b0;
    fire = 3'h0;
    for (t = 0; t < 20 && busy !== 1'b1; t++) cyc();
    chk("busy up", {7'h0, busy}, 8'h01);
    if (busy !== 1'b1) conclude();
    if (!tm) chk("conv track", {7'h0, track}, 8'h00);
    // repeated start while running is to be ignored
    if (s == 0) bw = 1'b1;
    else if (s != 4) fire = 3'(s);
    cyc();
    bw = 1'b0;
    fire = 3'h0;
    last = -1;
    for (t = 0; t < 400 && busy === 1'b1; t++) begin
      cyc();
      if (tick === 1'b1) begin
        if (last >= 0) chk("tick gap", 8'(t - last), 8'(div) + 8'h01);
        last = t;
      end
    end
    if (busy !== 1'b0) begin
      n_errors++;
      conclude();
    end
    chk("done", {7'h0, done}, 8'h01);
    chk("result", res, exp);
    chk("irq", {7'h0, irq}, {7'h0, irqen});
    if (tm && s != 4) chk("track clks", 8'(n_trk), 8'(TRACK_CLKS));
    if (tm && s == 4) chk("strobe high track", {7'h0, track}, 8'h00);
    if (s == 4) fire = 3'h6;
    repeat (3) cyc();
    fire = 3'h0;
    chk("busy stays low", {7'h0, busy}, 8'h00);
    chk("result held", res, exp);
    dclr = 1'b1;
    cyc();
    dclr = 1'b0;
    cyc();
    chk("done cleared", {7'h0, done}, 8'h00);
  endtask
  initial begin
    repeat (12) cyc();
    rst = 1'b0;
    cyc();
    chk("reset result", res, RESULT_RESET);
    chk("reset done", {7'h0, done}, 8'h00);
    chk("reset gain", {6'h00, pga_gain}, {6'h00, GAIN_HALF});
    bw = 1'b1;
    cyc();
    bw = 1'b0;
    repeat (4) cyc();
    chk("off busy", {7'h0, busy}, 8'h00);
    chk("off track", {7'h0, track}, 8'h00);
    en = 1'b1;
    stby = 1'b1;
    repeat (2) cyc();
    chk("standby track", {7'h0, track}, 8'h00);
    stby = 1'b0;
    for (int p = 0; p < 16; p++) begin
      pos = 4'(p);
      neg = 4'(15 - p);
      gsel = 2'(p);
      cyc();
      chk("gain", {6'h00, pga_gain}, 8'(p % 4));
      chk("pos sel", {4'h0, pos_sel}, 8'(p));
      chk("neg sel", {5'h00, neg_sel}, 8'((15 - p) % 8));
      chk("reserved", {7'h0, prsv}, {7'h0, p > 9});
      chk("diff", {6'h00, diffm, ngnd}, {6'h00, p > 7, p < 8});
    end
    for (int i = 0; i < 30; i++) begin
      seed = nxt(seed);
      tm = seed[3];
      div = {3'h0, seed[5:4]};
      irqen = seed[6];
      split8 = seed[7];
      neg = seed[11:8];
      level = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[23:16];
      conv(i % 5);
    end
    conclude();
  end
endmodule

// ==== verilog/sacc_clkdiv.sv ====
// Purpose: sar clock enable divided from mclk by (div + 1)
// Assumes: one clock domain
// Notes: counter restarts whenever the block is not running
`timescale 1ns/1ns
module sacc_clkdiv
  import sacc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // sync reset
  input wire logic run, // counting allowed
  input wire logic [sacc_pkg::DIV_W-1:0] div, // divider field
  output logic tick // one-cycle sar clock enable
);
  logic [DIV_W-1:0] cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q >= div) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign tick = run && (cnt_q >= div); // [RQ7]
  // a divider of zero ticks every cycle, and so may a value rewritten to zero
  cnt_period_a: assert property (@(posedge mclk) disable iff (rst || !run) // [RQ7]
    tick && div != '0 && $stable(div) |=> (div == '0 || !tick) [*1])
    else $error("sar tick repeated too soon");
endmodule

// ==== verilog/sacc_edge.sv ====
// Purpose: rising edge detector for start sources
// Assumes: inputs synchronous to mclk
// Notes: one instance per edge-triggered source
`timescale 1ns/1ns
module sacc_edge (
  input wire logic mclk, // system clock
  input wire logic rst, // sync reset
  input wire logic sig, // sampled level
  output logic rise // one-cycle pulse on 0 to 1
);
  logic prev_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig;
    end
  end
  assign rise = sig && !prev_q;
endmodule

// ==== verilog/sacc_pkg.sv ====
// Purpose: shared constants for the sar converter control block
// Assumes: 25 MHz mclk, synchronous active-high reset
// Notes: field codes and reset values of the control and config bits
package sacc_pkg;
  localparam int RES_W = 8;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h1F;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [1:0] GAIN_HALF = 2'h0;
  localparam logic [1:0] GAIN_ONE = 2'h1;
  localparam logic [1:0] GAIN_TWO = 2'h2;
  localparam logic [1:0] GAIN_FOUR = 2'h3;
  localparam logic [2:0] START_SW = 3'h0;
  localparam logic [2:0] START_T0 = 3'h1;
  localparam logic [2:0] START_T2 = 3'h2;
  localparam logic [2:0] START_T1 = 3'h3;
  localparam int START_EXT_BIT = 2;
  localparam int NEG_GND_BIT = 3;
  localparam logic [3:0] POS_TEMP = 4'h8;
  localparam logic [3:0] POS_SUPPLY = 4'h9;
  localparam int POS_PIN_BIT = 3;
  localparam logic [3:0] TRACK_CLKS = 4'h3;
  localparam logic [3:0] CONV_CLKS = 4'h8;
  localparam logic [RES_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [RES_W-1:0] SIGN_FLIP = 8'h80;
  typedef enum logic [1:0] {SACC_IDLE, SACC_TRACK, SACC_CONV} sacc_state_t;
endpackage

// ==== verilog/sacc_top.sv ====
// Purpose: digital control of an 8-bit successive-approximation converter
// Assumes: single 25 MHz clock, all inputs synchronous, analog comparator outside
// Notes: control bits are plain ports; the result register is a flip-flop bank
// Functional notes
// [RQ1] Converter runs only when enabled; otherwise shutdown, no conversions.
// [RQ2] Ground negative input means single-ended; anything else means differential.
// [RQ3] Single-ended results are 8-bit unsigned, 0x00 to 0xFF.
// [RQ4] Differential results are two's complement, 0x80 to 0x7F.
// [RQ5] Gain choices 0.5, 1, 2, 4; reset default is 0.5.
// [RQ6] Gain field 00=0.5, 01=1, 10=2, 11=4.
// [RQ7] Sar clock is mclk divided by divider field plus one.
// [RQ8] Five start sources: software, timer 0, timer 2, timer 1, strobe.
// [RQ9] Start mode 000 sw, 001 t0, 010 t2, 011 t1, 1xx strobe.
// [RQ10] In software mode each busy write of one starts a conversion.
// [RQ11] Busy reads one throughout conversion, zero after completion.
// [RQ12] Busy falling edge sets done flag and requests interrupt if enabled.
// [RQ13] Result register holds new result once done flag reads one.
// [RQ14] Polling software should test done flag, not busy.
// [RQ15] Timer 2 source uses low overflow in 8-bit, high in 16-bit.
// [RQ16] Normal track mode tracks continuously while enabled, except converting.
// [RQ17] Low-power mode tracks three sar clocks after start, then converts.
// [RQ18] Low-power strobe mode tracks while strobe low; converts at rising edge.
// [RQ19] Normal mode with strobe selected starts on strobe rising edge.
// [RQ20] Tracking can be shut down during standby or sleep.
// [RQ21] Positive input: pins, temperature, supply; negative: pins or ground.
// [RQ22] Positive codes 0-7 pins, 8 temperature, 9 supply, 10-15 reserved.
// [RQ23] Start events during a running conversion are ignored.
`timescale 1ns/1ns
module sacc_top
  import sacc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic converter_enable_bit, // subsystem enable
  input wire logic track_mode_bit, // 1 = low-power tracking
  input wire logic [2:0] start_mode_field, // start source select
  input wire logic busy_write_one, // pulse: software wrote 1 to busy
  input wire logic done_flag_clear, // pulse: software clears done flag
  input wire logic done_irq_enable, // interrupt enable for done flag
  input wire logic [sacc_pkg::DIV_W-1:0] sar_clock_divider_field, // divider
  input wire logic [1:0] gain_select_field, // amplifier gain code
  input wire logic [3:0] positive_input_field, // positive mux code
  input wire logic [3:0] negative_input_field, // negative mux code
  input wire logic timer0_ovf, // pulse: timer 0 overflow
  input wire logic timer1_ovf, // pulse: timer 1 overflow
  input wire logic timer2_low_ovf, // pulse: timer 2 low byte overflow
  input wire logic timer2_high_ovf, // pulse: timer 2 high byte overflow
  input wire logic timer2_split8, // timer 2 in 8-bit mode
  input wire logic external_start_strobe, // external conversion start
  input wire logic standby, // chip in standby or sleep
  input wire logic cmp_above, // analog comparator: input above trial
  output logic [sacc_pkg::RES_W-1:0] conversion_result_reg, // result
  output logic conversion_busy_bit, // conversion running
  output logic conversion_done_flag, // sticky completion flag
  output logic done_irq, // completion interrupt request
  output logic track_en, // sample switch closed
  output logic sar_clk_en, // sar clock enable pulse
  output logic [sacc_pkg::RES_W-1:0] sar_trial, // dac trial code
  output logic diff_mode, // 1 = differential
  output logic [1:0] pga_gain, // gain code to amplifier
  output logic [3:0] pos_sel, // positive mux select
  output logic [2:0] neg_sel, // negative pin select
  output logic neg_gnd, // negative input on ground
  output logic pos_reserved // positive code reserved
);
  import sacc_pkg::*;

  sacc_state_t state_q;
  logic [3:0] cnt_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] bit_q;
  logic [RES_W-1:0] sar_d;
  logic busy_q;
  logic done_q;
  logic [1:0] gain_q;
  logic run;
  logic tick;
  logic strobe_rise;
  logic t2_evt;
  logic start_evt;
  logic strobe_low_mode;

  // divider held off in shutdown so no sar clocks burn power
  assign run = converter_enable_bit;
  sacc_clkdiv #() u_div (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .div(sar_clock_divider_field),
    .tick(tick)
  );
  sacc_edge u_strobe (
    .mclk(mclk),
    .rst(rst),
    .sig(external_start_strobe),
    .rise(strobe_rise)
  );
  assign t2_evt = timer2_split8 ? timer2_low_ovf : timer2_high_ovf; // [RQ15]
  assign strobe_low_mode = track_mode_bit && start_mode_field[START_EXT_BIT];

  // source selection; 1xx is the strobe whatever the low bits say
  always_comb begin
    if (start_mode_field[START_EXT_BIT]) begin
      start_evt = strobe_rise; // [RQ19] [RQ18]
    end else begin
      case (start_mode_field)
        START_SW: start_evt = busy_write_one; // [RQ10]
        START_T0: start_evt = timer0_ovf;
        START_T2: start_evt = t2_evt;
        START_T1: start_evt = timer1_ovf; // [RQ8] [RQ9]
        default: start_evt = 1'b0;
      endcase
    end
  end

  // sequencer: starts only from idle, so a late start cannot disturb a run
  always_ff @(posedge mclk) begin
    if (rst || !converter_enable_bit) begin // [RQ1]
      state_q <= SACC_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        SACC_IDLE: begin
          if (start_evt) begin // [RQ23]
            cnt_q <= '0;
            // strobe mode already tracked while the strobe sat low
            state_q <= (track_mode_bit && !strobe_low_mode) ? SACC_TRACK : SACC_CONV;
          end
        end
        SACC_TRACK: begin
          if (tick) begin
            if (cnt_q == TRACK_CLKS - 4'h1) begin // [RQ17]
              cnt_q <= '0;
              state_q <= SACC_CONV;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        SACC_CONV: begin
          if (tick) begin
            if (cnt_q == CONV_CLKS - 4'h1) begin
              cnt_q <= '0;
              state_q <= SACC_IDLE;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        default: state_q <= SACC_IDLE;
      endcase
    end
  end

  // next trial: keep or drop the bit under test, then try the next one down;
  // the result register takes this value, so the lsb decision is not lost
  always_comb begin
    if (cmp_above) begin
      sar_d = sar_q | (bit_q >> 1);
    end else begin
      sar_d = (sar_q & ~bit_q) | (bit_q >> 1);
    end
  end

  // successive approximation, one bit per sar clock, msb first
  always_ff @(posedge mclk) begin
    if (rst) begin
      sar_q <= '0;
      bit_q <= '0;
    end else if (state_q != SACC_CONV) begin
      sar_q <= SIGN_FLIP;
      bit_q <= SIGN_FLIP;
    end else if (tick) begin
      sar_q <= sar_d;
      bit_q <= bit_q >> 1;
    end
  end

  // result latched as the run finishes; offset binary flipped to two's complement in differential mode only
  always_ff @(posedge mclk) begin
    if (rst) begin
      conversion_result_reg <= RESULT_RESET;
    end else if (state_q == SACC_CONV && tick && cnt_q == CONV_CLKS - 4'h1) begin
      if (diff_mode) begin
        conversion_result_reg <= sar_d ^ SIGN_FLIP; // [RQ4]
      end else begin
        conversion_result_reg <= sar_d; // [RQ3]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != SACC_IDLE); // [RQ11]
    end
  end

  // done flag: set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (busy_q && state_q == SACC_IDLE) begin
      done_q <= 1'b1; // [RQ12] [RQ13]
    end else if (done_flag_clear) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gain_q <= GAIN_RESET; // [RQ5]
    end else begin
      gain_q <= gain_select_field; // [RQ6]
    end
  end

  assign conversion_busy_bit = busy_q;
  assign conversion_done_flag = done_q;
  assign done_irq = done_q && done_irq_enable; // [RQ12]
  assign sar_clk_en = tick;
  assign sar_trial = sar_q;
  assign pga_gain = gain_q;
  assign neg_gnd = negative_input_field[NEG_GND_BIT]; // [RQ21]
  assign neg_sel = negative_input_field[2:0];
  assign diff_mode = !neg_gnd; // [RQ2]
  assign pos_sel = positive_input_field;
  assign pos_reserved = positive_input_field > POS_SUPPLY; // [RQ22]

  // tracking; standby opens the switch whatever the mode
  always_comb begin
    if (!converter_enable_bit || standby) begin // [RQ20]
      track_en = 1'b0;
    end else if (!track_mode_bit) begin
      track_en = (state_q == SACC_IDLE); // [RQ16]
    end else if (strobe_low_mode) begin
      track_en = (state_q == SACC_IDLE) && !external_start_strobe; // [RQ18]
    end else begin
      track_en = (state_q == SACC_TRACK); // [RQ17]
    end
  end

  shutdown_idle_a: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
    !converter_enable_bit |=> state_q == SACC_IDLE)
    else $error("sequencer active while disabled");
  busy_fall_done_a: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    $fell(busy_q) |-> done_q)
    else $error("done flag not set on busy fall");
  sw_start_a: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
    converter_enable_bit && state_q == SACC_IDLE && start_mode_field == START_SW
    && busy_write_one ##1 converter_enable_bit |=> busy_q)
    else $error("software start did not raise busy");
  no_restart_a: assert property (@(posedge mclk) disable iff (rst) // [RQ23]
    state_q == SACC_CONV && converter_enable_bit && !tick |=> state_q == SACC_CONV)
    else $error("running conversion disturbed");
  mode_map_a: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
    diff_mode == (negative_input_field < 4'h8))
    else $error("mode decode wrong");
  // the very first edge has no reset history, so only the release edge is checked
  gain_reset_a: assert property (@(posedge mclk) // [RQ5]
    $past(rst) && !rst |-> pga_gain == GAIN_HALF)
    else $error("gain not at half after reset");
  track_conv_a: assert property (@(posedge mclk) disable iff (rst) // [RQ16]
    state_q == SACC_CONV |-> !track_en)
    else $error("tracking during conversion");
  irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    done_irq |-> done_q && done_irq_enable)
    else $error("interrupt without flag");
  result_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
    state_q != SACC_CONV |=> $stable(conversion_result_reg))
    else $error("result changed outside a conversion");
  busy_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
    state_q != SACC_IDLE |=> busy_q)
    else $error("busy low while sequencer runs");
  done_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    done_q && !done_flag_clear |=> done_q)
    else $error("done flag lost without a clear");
  gain_copy_a: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
    1'b1 |=> pga_gain == $past(gain_select_field))
    else $error("gain code not passed to amplifier");
  shutdown_track_a: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
    !converter_enable_bit |-> !track_en && !sar_clk_en)
    else $error("tracking or sar clock while disabled");
  track_entry_a: assert property (@(posedge mclk) disable iff (rst) // [RQ17]
    converter_enable_bit && state_q == SACC_IDLE && start_evt && track_mode_bit
    && !strobe_low_mode |=> state_q == SACC_TRACK)
    else $error("low-power start skipped tracking");
  strobe_conv_a: assert property (@(posedge mclk) disable iff (rst) // [RQ18]
    converter_enable_bit && state_q == SACC_IDLE && start_evt && strobe_low_mode
    |=> state_q == SACC_CONV)
    else $error("strobe start did not convert at once");
  strobe_start_a: assert property (@(posedge mclk) disable iff (rst) // [RQ19]
    converter_enable_bit && state_q == SACC_IDLE && !track_mode_bit
    && start_mode_field[START_EXT_BIT] && strobe_rise |=> state_q == SACC_CONV)
    else $error("strobe edge did not start a conversion");
  t2_source_a: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
    converter_enable_bit && state_q == SACC_IDLE && start_mode_field == START_T2
    && (timer2_split8 ? timer2_low_ovf : timer2_high_ovf) |=> state_q != SACC_IDLE)
    else $error("timer 2 overflow did not start");
  reserved_code_a: assert property (@(posedge mclk) disable iff (rst) // [RQ22]
    pos_reserved == (positive_input_field[3] && positive_input_field[2:1] != 2'h0))
    else $error("reserved input code decode wrong");
endmodule
